// ===== core/phase_frequency_detector.sv
`timescale 1ns/1ns
`default_nettype none
module phase_frequency_detector
    import pfd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic vco_div_pulse,
    input wire logic ref_pulse,
    output logic vco_side_flop,
    output logic ref_side_flop,
    output pfd_steer_t steer
);
    // pins are sampled as ordinary inputs; the flops act on sampled edges
    logic vco_level;
    logic vco_rise;
    logic ref_level;
    logic ref_rise;
    pfd_state_t st;
    pfd_state_t next_st;

    pfd_edge_sync vco_sync_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(vco_div_pulse),
        .level(vco_level),
        .rise(vco_rise)
    );

    pfd_edge_sync ref_sync_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(ref_pulse),
        .level(ref_level),
        .rise(ref_rise)
    );

    always_comb begin
        next_st = st;
        next_st.vco_sync = vco_level;
        next_st.ref_sync = ref_level;
        // vco flop: clocked by vco edge, data from ref flop
        if (vco_rise) begin
            next_st.vco_side_flop = st.ref_side_flop;
        end
        // ref flop: clocked by ref edge, data from vco flop
        if (ref_rise) begin
            next_st.ref_side_flop = st.vco_side_flop;
        end
        // async-style overrides while the pulses stand high
        if (vco_level) begin
            next_st.ref_side_flop = flop_clear;
        end
        if (ref_level) begin
            next_st.vco_side_flop = flop_set;
        end
        // current steering follows the flops
        next_st.speedup_steer_path = next_st.ref_side_flop;
        next_st.integrator_draw_path = ~next_st.vco_side_flop;
        next_st.alternate_source_path = next_st.vco_side_flop;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= pfd_reset_st;
        end else begin
            st <= next_st;
        end
    end

    assign vco_side_flop = st.vco_side_flop;
    assign ref_side_flop = st.ref_side_flop;
    assign steer.speedup_steer_path = st.speedup_steer_path;
    assign steer.integrator_draw_path = st.integrator_draw_path;
    assign steer.alternate_source_path = st.alternate_source_path;

    a_ref_flop_reset: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        vco_level |=> !st.ref_side_flop)
        else $error("ref flop not held clear by vco pulse");

    a_vco_flop_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ref_level |=> st.vco_side_flop)
        else $error("vco flop not held set by ref pulse");

    a_ref_data_path: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_rise && !vco_level) |=>
        st.ref_side_flop == $past(st.vco_side_flop))
        else $error("ref flop did not capture vco flop");

    a_vco_data_path: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (vco_rise && !ref_level) |=>
        st.vco_side_flop == $past(st.ref_side_flop))
        else $error("vco flop did not capture ref flop");

    a_speedup_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st.ref_side_flop && vco_level) |=> !steer.speedup_steer_path)
        else $error("speed-up not cleared by vco pulse");

    a_speedup_match: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        steer.speedup_steer_path == st.ref_side_flop)
        else $error("speed-up path disagrees with ref flop");

    a_draw_exclusive: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        steer.integrator_draw_path != steer.alternate_source_path)
        else $error("ramp source not exclusive");

    a_draw_window: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        steer.integrator_draw_path == !st.vco_side_flop)
        else $error("ramp window does not follow vco flop");

    a_ref_hold_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (vco_level && ref_rise) |=> !st.ref_side_flop)
        else $error("ref edge beat the vco reset level");

    a_vco_hold_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_level && vco_rise) |=> st.vco_side_flop)
        else $error("vco edge beat the ref set level");

    a_vco_flop_keep: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!vco_rise && !ref_level) |=> $stable(st.vco_side_flop))
        else $error("vco flop moved without a cause");

    a_ref_flop_keep: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!ref_rise && !vco_level) |=> $stable(st.ref_side_flop))
        else $error("ref flop moved without a cause");

    a_vco_fall_cause: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(st.vco_side_flop) |-> $past(vco_rise))
        else $error("vco flop fell without a vco edge");

    a_ref_rise_cause: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(st.ref_side_flop) |-> $past(ref_rise))
        else $error("ref flop rose without a ref edge");

    a_vco_rise_cause: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(st.vco_side_flop) |-> ($past(ref_level) || $past(vco_rise)))
        else $error("vco flop rose without a cause");

    a_ref_fall_cause: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(st.ref_side_flop) |-> ($past(vco_level) || $past(ref_rise)))
        else $error("ref flop fell without a cause");

    a_no_speedup_lead: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_rise && !vco_level && !st.vco_side_flop) |=>
        !st.ref_side_flop)
        else $error("speed-up set while vco leads");

    a_no_steer_lead: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_rise && !vco_level && !st.vco_side_flop) |=>
        !steer.speedup_steer_path)
        else $error("speed-up current on while vco leads");

    a_speedup_on_lead: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_rise && !vco_level && st.vco_side_flop) |=>
        steer.speedup_steer_path)
        else $error("speed-up not raised while ref leads");

    a_speedup_stop: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (vco_level && steer.speedup_steer_path) |=>
        !steer.speedup_steer_path)
        else $error("speed-up current not stopped by vco");

    a_window_shut: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_rise && !vco_level && st.vco_side_flop) |=>
        (st.vco_side_flop && !steer.integrator_draw_path))
        else $error("ramp window opened while ref leads");

    a_vco_keep_lead: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (vco_rise && !ref_level && st.ref_side_flop) |=>
        st.vco_side_flop)
        else $error("vco flop dropped while ref leads");

    a_window_open: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (vco_rise && !ref_level && !st.ref_side_flop) |=>
        steer.integrator_draw_path)
        else $error("ramp window not opened by vco edge");

    a_window_close: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ref_level && !st.vco_side_flop) |=>
        !steer.integrator_draw_path)
        else $error("ramp window not closed by ref level");

    a_draw_when_low: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (vco_rise && !ref_level && !st.ref_side_flop) |=>
        !steer.alternate_source_path)
        else $error("alternate source on during window");

    a_alt_when_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ref_level |=> steer.alternate_source_path)
        else $error("alternate source off after ref level");

    a_alt_follows: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        steer.alternate_source_path == st.vco_side_flop)
        else $error("alternate source disagrees with vco flop");

    a_reset_clear: assert property (
        @(posedge ref_clk)
        !rst_n |=> (!vco_side_flop && !ref_side_flop))
        else $error("flops not clear after reset");

    a_reset_steer: assert property (
        @(posedge ref_clk)
        !rst_n |=> (!steer.speedup_steer_path &&
        !steer.alternate_source_path))
        else $error("steering active after reset");
endmodule // phase_frequency_detector
`default_nettype wire

// ===== common/pfd_pkg.sv
package pfd_pkg;
    localparam logic flop_clear = 1'h0;
    localparam logic flop_set = 1'h1;

    typedef struct packed {
        logic vco_meta;
        logic vco_sync;
        logic vco_prev;
        logic ref_meta;
        logic ref_sync;
        logic ref_prev;
        logic vco_side_flop;
        logic ref_side_flop;
        logic speedup_steer_path;
        logic integrator_draw_path;
        logic alternate_source_path;
    } pfd_state_t;

    // reset: both flops clear, so the ramp is drawn from the integrator
    localparam pfd_state_t pfd_reset_st = '{
        integrator_draw_path: flop_set,
        default: flop_clear
    };

    typedef struct packed {
        logic speedup_steer_path;
        logic integrator_draw_path;
        logic alternate_source_path;
    } pfd_steer_t;
endpackage

// ===== core/pfd_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pfd_edge_sync
    import pfd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= flop_clear;
            sync <= flop_clear;
            prev <= flop_clear;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
endmodule // pfd_edge_sync
`default_nettype wire

// ===== test/pfd_src.sv
`timescale 1ns/1ns
`default_nettype none
module pfd_src (
    input wire logic ref_clk,
    output logic vco_div_pulse,
    output logic ref_pulse
);
    logic sample_hold;
    initial begin
        vco_div_pulse = 1'h0;
        ref_pulse = 1'h0;
        sample_hold = 1'h0;
    end
    // one 1000-clock period, 4-clock pulses, lead in clocks
    task automatic pair(input int lead);
        for (int i = 0; i < 1000; i++) begin
            @(posedge ref_clk);
            #1;
            vco_div_pulse = (i + (lead < 0 ? lead : 0)) inside {[0:3]};
            ref_pulse = (i - (lead > 0 ? lead : 0)) inside {[0:3]};
            sample_hold = (i < 2);
        end
    endtask
endmodule // pfd_src
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pfd_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic vco_div_pulse, ref_pulse, vco_side_flop, ref_side_flop;
    logic seen = 1'h0;
    pfd_steer_t steer;
    int errors = 0, checks_done = 0, cyc = 0, low = 0, v = 0, r = 0, up = 0;
    always #5 ref_clk = ~ref_clk;
    pfd_src u_src (.ref_clk(ref_clk), .vco_div_pulse(vco_div_pulse),
        .ref_pulse(ref_pulse));
    phase_frequency_detector u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .vco_div_pulse(vco_div_pulse), .ref_pulse(ref_pulse),
        .vco_side_flop(vco_side_flop), .ref_side_flop(ref_side_flop),
        .steer(steer));
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (vco_side_flop === 1'h0) low <= low + 1;
        if (ref_side_flop === 1'h1) seen <= 1'h1;
        if (cyc == 40000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one period through the integer model, then compare
    task automatic run(input int lead);
        int vs;
        vs = v;
        low = 0;
        seen = 1'h0;
        if (lead > 0) begin
            v = r;
            r = v;
            v = 1;
            up = r;
        end else begin
            r = v;
            v = 1;
            up = r;
            v = r;
            r = 0;
        end
        u_src.pair(lead);
        chk(vco_side_flop, v[0]);
        chk(ref_side_flop, r[0]);
        chk(seen, up[0]);
        chk(steer, {r[0], ~v[0], v[0]});
        if (vs == 1) chk(low, (lead > 0) ? lead : 0);
    endtask
    task automatic results();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(12));
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1 chk({vco_side_flop, ref_side_flop, steer}, 32'h2);
        for (int i = 0; i < 24; i++) begin
            if (i % 3 == 2)
                run(-int'($urandom_range(40, 6)));
            else
                run(int'($urandom_range(300, 6)));
        end
        results();
    end
endmodule // tb
`default_nettype wire
